// File: design/scg_host.sv
// controller end: ahb-lite command registers, ordering checks and link driver
// Functional notes
// RULE1 - enable sai only while other channels idle
// RULE2 - left-to-right swap passes through both cleared
// RULE3 - config, clocks, mute, then channel enable; the code checks only config then mute before enable
// RULE4 - enable at least 10ms before silence ends
// RULE5 - mute channel differs from sai playback channel
// RULE6 - config discarded while either enable set
// RULE7 - first format discarded while either enable set
// RULE8 - second format discarded while either enable set
// RULE9 - mode discarded while either enable set
// RULE10 - silence length at least 04h
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module scg_host #(
    parameter int UNIT_CYC = scg_pkg::SCG_UNIT_CYC
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // link
    scg_link_if.host link
);
    import scg_pkg::*;

    typedef enum {SCG_ST_IDLE, SCG_ST_WAIT} scg_state_t;

    scg_state_t st_r, st_nxt;
    logic [18:0] word_r, word_nxt, pend_word_r, pend_word_nxt;
    logic pend_r, pend_nxt, req_tgl_r, req_tgl_nxt;
    logic [2:0] err_r, err_nxt;
    logic cfg_sent_r, cfg_sent_nxt, mute_sent_r, mute_sent_nxt;
    logic [7:0] mute_len_r, mute_len_nxt;
    logic [3:0] mute_ch_r, mute_ch_nxt;
    logic [7:0] units_r, units_nxt;
    logic [31:0] ucnt_r, ucnt_nxt;
    logic wr_pend_r, rd_go, ap_wr;
    logic [3:0] ap_addr_r;
    logic [31:0] hrdata_r, rd_val;
    logic [2:0] ack_s_r;
    logic [5:0] dev_s1_r, dev_s2_r;
    logic dev_left, dev_right;
    logic [3:0] dev_busy;
    logic ack_edge, cmd_wr;
    logic [2:0] req_op;
    logic [15:0] req_data;
    logic [2:0] lk_req_s_r;
    logic lk_valid_r, lk_ack_tgl_r, lk_ack_due_r;
    logic [18:0] lk_word_r;

    // ahb address phase; zero wait state, always okay
    assign ap_wr = hsel && hready && htrans[1] && hwrite;
    assign rd_go = hsel && hready && htrans[1] && !hwrite;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign cmd_wr = wr_pend_r && (ap_addr_r == SCG_REG_CMD);

    // device state arrives from the link domain, two stages each
    assign dev_left = dev_s2_r[0];
    assign dev_right = dev_s2_r[1];
    assign dev_busy = dev_s2_r[5:2];
    assign ack_edge = ack_s_r[2] ^ ack_s_r[1];
    assign req_op = hwdata[SCG_CMD_OP_LO+2:SCG_CMD_OP_LO];
    assign req_data = hwdata[15:0];

    // status view; unmapped offsets read zero
    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (haddr[3:0] == SCG_REG_STAT)
        begin
            rd_val[SCG_ST_BUSY] = (st_r != SCG_ST_IDLE);
            rd_val[SCG_ST_LEFT] = dev_left;
            rd_val[SCG_ST_RIGHT] = dev_right;
            rd_val[SCG_ST_BUSYLOW_LO+3:SCG_ST_BUSYLOW_LO] = dev_busy;
            rd_val[SCG_ST_ERR_LO+2:SCG_ST_ERR_LO] = err_r;
            rd_val[SCG_ST_CFG] = cfg_sent_r;
            rd_val[SCG_ST_MUTE] = mute_sent_r;
        end
    end

    // command gating and sequencer; a refused command never reaches the link
    always_comb
    begin
        st_nxt = st_r;
        word_nxt = word_r;
        pend_word_nxt = pend_word_r;
        pend_nxt = pend_r;
        req_tgl_nxt = req_tgl_r;
        err_nxt = err_r;
        cfg_sent_nxt = cfg_sent_r;
        mute_sent_nxt = mute_sent_r;
        mute_len_nxt = mute_len_r;
        mute_ch_nxt = mute_ch_r;
        units_nxt = units_r;
        ucnt_nxt = ucnt_r;
        // silence age in length steps, saturating
        if (mute_sent_r && units_r != 8'hff)
        begin
            if (ucnt_r == 32'(UNIT_CYC - 1))
            begin
                ucnt_nxt = 32'h0000_0000;
                units_nxt = units_r + 8'h01;
            end
            else
                ucnt_nxt = ucnt_r + 32'h0000_0001;
        end
        if (st_r == SCG_ST_WAIT && ack_edge)
        begin
            if (pend_r)
            begin
                word_nxt = pend_word_r;
                req_tgl_nxt = !req_tgl_r;
                pend_nxt = 1'b0;
            end
            else
                st_nxt = SCG_ST_IDLE;
        end
        if (cmd_wr)
        begin
            if (st_r != SCG_ST_IDLE)
                err_nxt = SCG_ERR_BUSY; // one command in flight at a time
            else
            begin
                err_nxt = SCG_ERR_NONE;
                if (req_op == SCG_OP_MUTE && req_data[7:0] < SCG_MUTE_LEN_MIN)
                    err_nxt = SCG_ERR_SHORT; // RULE10
                if (req_op == SCG_OP_CHEN && (req_data[SCG_CHEN_LEFT] || req_data[SCG_CHEN_RIGHT]))
                begin
                    if (dev_busy != 4'hf)
                        err_nxt = SCG_ERR_CHBUSY; // RULE1
                    else if (!cfg_sent_r || !mute_sent_r)
                        err_nxt = SCG_ERR_ORDER; // RULE3
                    else if ({1'b0, units_r} + SCG_LEAD_UNITS >= {1'b0, mute_len_r})
                        err_nxt = SCG_ERR_LATE; // RULE4
                    else if ((req_data[SCG_CHEN_MASK_LO+3:SCG_CHEN_MASK_LO] & mute_ch_r) != 4'h0)
                        err_nxt = SCG_ERR_OVERLAP; // RULE5
                end
                if (err_nxt == SCG_ERR_NONE)
                begin
                    st_nxt = SCG_ST_WAIT;
                    req_tgl_nxt = !req_tgl_r;
                    word_nxt = {req_op, req_data};
                    // direct left-to-right swap first clears both halves
                    if (req_op == SCG_OP_CHEN && dev_left && !dev_right
                        && !req_data[SCG_CHEN_LEFT] && req_data[SCG_CHEN_RIGHT])
                    begin
                        word_nxt = {SCG_OP_CHEN, 16'h0000}; // RULE2
                        pend_word_nxt = {req_op, req_data}; // RULE2
                        pend_nxt = 1'b1;
                    end
                    // config restarts the bring-up order; device drops it when enabled
                    if (req_op == SCG_OP_CFG && !dev_left && !dev_right)
                    begin
                        cfg_sent_nxt = 1'b1; // RULE3
                        mute_sent_nxt = 1'b0;
                    end
                    if (req_op == SCG_OP_MUTE && cfg_sent_r)
                    begin
                        mute_sent_nxt = 1'b1; // RULE3
                        mute_len_nxt = req_data[7:0];
                        mute_ch_nxt = req_data[SCG_MUTE_CH_LO+3:SCG_MUTE_CH_LO];
                        units_nxt = 8'h00;
                        ucnt_nxt = 32'h0000_0000;
                    end
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r <= SCG_ST_IDLE;
            word_r <= 19'h00000;
            pend_word_r <= 19'h00000;
            pend_r <= 1'b0;
            req_tgl_r <= 1'b0;
            err_r <= SCG_ERR_NONE;
            cfg_sent_r <= 1'b0;
            mute_sent_r <= 1'b0;
            mute_len_r <= 8'h00;
            mute_ch_r <= 4'h0;
            units_r <= 8'h00;
            ucnt_r <= 32'h0000_0000;
            wr_pend_r <= 1'b0;
            ap_addr_r <= 4'h0;
            hrdata_r <= 32'h0000_0000;
            ack_s_r <= 3'h0;
            dev_s1_r <= 6'h3c;
            dev_s2_r <= 6'h3c;
        end
        else
        begin
            st_r <= st_nxt;
            word_r <= word_nxt;
            pend_word_r <= pend_word_nxt;
            pend_r <= pend_nxt;
            req_tgl_r <= req_tgl_nxt;
            err_r <= err_nxt;
            cfg_sent_r <= cfg_sent_nxt;
            mute_sent_r <= mute_sent_nxt;
            mute_len_r <= mute_len_nxt;
            mute_ch_r <= mute_ch_nxt;
            units_r <= units_nxt;
            ucnt_r <= ucnt_nxt;
            wr_pend_r <= ap_wr;
            ap_addr_r <= haddr[3:0];
            hrdata_r <= rd_go ? rd_val : 32'h0000_0000;
            ack_s_r <= {ack_s_r[1:0], lk_ack_tgl_r};
            dev_s1_r <= {link.busy_low, link.right_en, link.left_en};
            dev_s2_r <= dev_s1_r;
        end
    end

    // link side: word is stable while the request toggle is in flight
    always_ff @(posedge link.link_clk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lk_req_s_r <= 3'h0;
            lk_valid_r <= 1'b0;
            lk_word_r <= 19'h00000;
            lk_ack_due_r <= 1'b0;
            lk_ack_tgl_r <= 1'b0;
        end
        else
        begin
            lk_req_s_r <= {lk_req_s_r[1:0], req_tgl_r};
            lk_valid_r <= lk_req_s_r[2] ^ lk_req_s_r[1];
            if (lk_req_s_r[2] ^ lk_req_s_r[1])
                lk_word_r <= word_r;
            // ack two cycles after the strobe so device state is settled
            lk_ack_due_r <= lk_valid_r;
            if (lk_ack_due_r)
                lk_ack_tgl_r <= !lk_ack_tgl_r;
        end
    end

    assign link.cmd_valid = lk_valid_r;
    assign link.cmd_op = lk_word_r[18:16];
    assign link.cmd_data = lk_word_r[15:0];
endmodule

// File: design/scg_pkg.sv
// shared constants and types for the sai command gating link
package scg_pkg;
    // command opcodes carried on the link
    typedef enum logic [2:0] {
        SCG_OP_CFG = 3'h1,
        SCG_OP_FMT1 = 3'h2,
        SCG_OP_FMT2 = 3'h3,
        SCG_OP_MODE = 3'h4,
        SCG_OP_MUTE = 3'h5,
        SCG_OP_CHEN = 3'h6
    } scg_op_t;
    localparam int SCG_DW = 16;
    // channel enable command fields
    localparam int SCG_CHEN_LEFT = 0;
    localparam int SCG_CHEN_RIGHT = 1;
    localparam int SCG_CHEN_MASK_LO = 2;
    // silence insert command fields: length in low byte, channel mask above
    localparam int SCG_MUTE_CH_LO = 8;
    localparam logic [7:0] SCG_MUTE_LEN_MIN = 8'h04;
    // register map of the controller, byte offsets
    localparam logic [3:0] SCG_REG_CMD = 4'h0;
    localparam logic [3:0] SCG_REG_STAT = 4'h4;
    localparam int SCG_CMD_OP_LO = 16;
    // status register fields
    localparam int SCG_ST_BUSY = 0;
    localparam int SCG_ST_LEFT = 1;
    localparam int SCG_ST_RIGHT = 2;
    localparam int SCG_ST_BUSYLOW_LO = 4;
    localparam int SCG_ST_ERR_LO = 8;
    localparam int SCG_ST_CFG = 11;
    localparam int SCG_ST_MUTE = 12;
    // refusal codes shown in status
    localparam logic [2:0] SCG_ERR_NONE = 3'h0;
    localparam logic [2:0] SCG_ERR_BUSY = 3'h1;
    localparam logic [2:0] SCG_ERR_CHBUSY = 3'h2;
    localparam logic [2:0] SCG_ERR_ORDER = 3'h3;
    localparam logic [2:0] SCG_ERR_LATE = 3'h4;
    localparam logic [2:0] SCG_ERR_OVERLAP = 3'h5;
    localparam logic [2:0] SCG_ERR_SHORT = 3'h6;
    // timing: one silence length step and the lead before silence ends
    localparam int SCG_CLK_KHZ = 20000;
    localparam int SCG_UNIT_MS = 5;
    localparam int SCG_LEAD_MS = 10;
    localparam int SCG_UNIT_CYC = SCG_UNIT_MS * SCG_CLK_KHZ;
    localparam logic [8:0] SCG_LEAD_UNITS = 9'(SCG_LEAD_MS / SCG_UNIT_MS);
endpackage

// File: design/scg_link_if.sv
// command link between the controller and the sai gating device
`timescale 1ns/1ps
interface scg_link_if (
    input wire logic link_clk
);
    logic cmd_valid;
    logic [2:0] cmd_op;
    logic [15:0] cmd_data;
    logic left_en;
    logic right_en;
    logic [3:0] busy_low;

    modport dev (
        input link_clk,
        input cmd_valid,
        input cmd_op,
        input cmd_data,
        output left_en,
        output right_en,
        output busy_low
    );
    modport host (
        input link_clk,
        output cmd_valid,
        output cmd_op,
        output cmd_data,
        input left_en,
        input right_en,
        input busy_low
    );
endinterface

// File: design/scg_device.sv
// sai command gating device end, runs on the link clock
`timescale 1ns/1ps
module scg_device (
    // reset
    input wire logic hresetn,
    // link
    scg_link_if.dev link,
    // playback channel state
    input wire logic [3:0] channel_busy_low,
    // applied settings
    output logic left_sai_enable,
    output logic right_sai_enable,
    output logic [3:0] sai_play_ch,
    output logic [15:0] sai_config_cmd,
    output logic [15:0] sai_format_first_cmd,
    output logic [15:0] sai_format_second_cmd,
    output logic [15:0] sai_mode_select_cmd,
    output logic [7:0] silence_length_field,
    output logic [3:0] silence_ch,
    output logic silence_insert_cmd,
    output logic cmd_discard
);
    import scg_pkg::*;

    logic left_r, left_nxt, right_r, right_nxt;
    logic [3:0] play_r, play_nxt;
    logic [15:0] cfg_r, cfg_nxt, fmt1_r, fmt1_nxt, fmt2_r, fmt2_nxt, mode_r, mode_nxt;
    logic [7:0] len_r, len_nxt;
    logic [3:0] sch_r, sch_nxt;
    logic mute_r, mute_nxt, disc_r, disc_nxt;
    logic [3:0] bsy_s1_r, bsy_s2_r;
    logic idle_en;

    // busy pins come from outside the link domain
    always_ff @(posedge link.link_clk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bsy_s1_r <= 4'hf;
            bsy_s2_r <= 4'hf;
        end
        else
        begin
            bsy_s1_r <= channel_busy_low;
            bsy_s2_r <= bsy_s1_r;
        end
    end

    // config, format and mode commands only land while both sai halves are stopped; silence insert always lands
    always_comb
    begin
        left_nxt = left_r;
        right_nxt = right_r;
        play_nxt = play_r;
        cfg_nxt = cfg_r;
        fmt1_nxt = fmt1_r;
        fmt2_nxt = fmt2_r;
        mode_nxt = mode_r;
        len_nxt = len_r;
        sch_nxt = sch_r;
        mute_nxt = 1'b0;
        disc_nxt = 1'b0;
        idle_en = !left_r && !right_r;
        if (link.cmd_valid)
        begin
            unique case (link.cmd_op)
                SCG_OP_CFG:
                    if (idle_en) cfg_nxt = link.cmd_data; // RULE6
                    else disc_nxt = 1'b1; // RULE6
                SCG_OP_FMT1:
                    if (idle_en) fmt1_nxt = link.cmd_data; // RULE7
                    else disc_nxt = 1'b1; // RULE7
                SCG_OP_FMT2:
                    if (idle_en) fmt2_nxt = link.cmd_data; // RULE8
                    else disc_nxt = 1'b1; // RULE8
                SCG_OP_MODE:
                    if (idle_en) mode_nxt = link.cmd_data; // RULE9
                    else disc_nxt = 1'b1; // RULE9
                SCG_OP_MUTE:
                begin
                    len_nxt = link.cmd_data[SCG_MUTE_CH_LO-1:0];
                    sch_nxt = link.cmd_data[SCG_MUTE_CH_LO+3:SCG_MUTE_CH_LO];
                    mute_nxt = 1'b1;
                end
                SCG_OP_CHEN:
                begin
                    left_nxt = link.cmd_data[SCG_CHEN_LEFT];
                    right_nxt = link.cmd_data[SCG_CHEN_RIGHT];
                    play_nxt = link.cmd_data[SCG_CHEN_MASK_LO+3:SCG_CHEN_MASK_LO];
                end
                default: disc_nxt = 1'b1; // unknown opcode is dropped
            endcase
        end
    end

    always_ff @(posedge link.link_clk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            left_r <= 1'b0;
            right_r <= 1'b0;
            play_r <= 4'h0;
            cfg_r <= 16'h0000;
            fmt1_r <= 16'h0000;
            fmt2_r <= 16'h0000;
            mode_r <= 16'h0000;
            len_r <= 8'h00;
            sch_r <= 4'h0;
            mute_r <= 1'b0;
            disc_r <= 1'b0;
        end
        else
        begin
            left_r <= left_nxt;
            right_r <= right_nxt;
            play_r <= play_nxt;
            cfg_r <= cfg_nxt;
            fmt1_r <= fmt1_nxt;
            fmt2_r <= fmt2_nxt;
            mode_r <= mode_nxt;
            len_r <= len_nxt;
            sch_r <= sch_nxt;
            mute_r <= mute_nxt;
            disc_r <= disc_nxt;
        end
    end

    // outputs straight from the registers
    assign left_sai_enable = left_r;
    assign right_sai_enable = right_r;
    assign sai_play_ch = play_r;
    assign sai_config_cmd = cfg_r;
    assign sai_format_first_cmd = fmt1_r;
    assign sai_format_second_cmd = fmt2_r;
    assign sai_mode_select_cmd = mode_r;
    assign silence_length_field = len_r;
    assign silence_ch = sch_r;
    assign silence_insert_cmd = mute_r;
    assign cmd_discard = disc_r;
    assign link.left_en = left_r;
    assign link.right_en = right_r;
    assign link.busy_low = bsy_s2_r;
endmodule

// File: verif/scg_link_sva.sv
// link-side assertions for the sai command gating link
`timescale 1ns/1ps
module scg_link_sva (
    // clock and reset
    input wire logic link_clk,
    input wire logic hresetn,
    // link signals
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_op,
    input wire logic [15:0] cmd_data,
    input wire logic left_en,
    input wire logic right_en,
    input wire logic [3:0] busy_low
);
    import scg_pkg::*;
    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (!hresetn);
    logic cfg_seen_r, cfg_seen_nxt, mute_seen_r, mute_seen_nxt;
    logic [3:0] mute_ch_r, mute_ch_nxt;
    logic chen_on, gated;
    // an enabling channel command and a gated setup command
    assign chen_on = cmd_valid && cmd_op == SCG_OP_CHEN && (|cmd_data[1:0]);
    assign gated = cmd_valid && cmd_op >= SCG_OP_CFG && cmd_op <= SCG_OP_MODE;
    // wire history; a config dropped by an enabled device restarts nothing
    always_comb
    begin
        cfg_seen_nxt = cfg_seen_r;
        mute_seen_nxt = mute_seen_r;
        mute_ch_nxt = mute_ch_r;
        if (cmd_valid && cmd_op == SCG_OP_CFG && !left_en && !right_en)
        begin
            cfg_seen_nxt = 1'b1;
            mute_seen_nxt = 1'b0;
        end
        if (cmd_valid && cmd_op == SCG_OP_MUTE)
        begin
            mute_seen_nxt = cfg_seen_r;
            mute_ch_nxt = cmd_data[11:8];
        end
    end
    // history registers
    always_ff @(posedge link_clk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg_seen_r <= 1'b0;
            mute_seen_r <= 1'b0;
            mute_ch_r <= 4'h0;
        end
        else
        begin
            cfg_seen_r <= cfg_seen_nxt;
            mute_seen_r <= mute_seen_nxt;
            mute_ch_r <= mute_ch_nxt;
        end
    end
    property p_chen_idle;
        chen_on |-> &(busy_low | cmd_data[5:2]);
    endproperty
    a_chen_idle: assert property (p_chen_idle) else $error("channel enable sent while a channel busy");
    property p_swap_via_off;
        cmd_valid && cmd_op == SCG_OP_CHEN && left_en && !right_en |-> !(cmd_data[1] && !cmd_data[0]);
    endproperty
    a_swap_via_off: assert property (p_swap_via_off) else $error("left to right swap skipped off");
    property p_chen_applies;
        cmd_valid && cmd_op == SCG_OP_CHEN |=> left_en == $past(cmd_data[0]) && right_en == $past(cmd_data[1]);
    endproperty
    a_chen_applies: assert property (p_chen_applies) else $error("enables did not follow command");
    property p_chen_after_mute;
        chen_on |-> mute_seen_r;
    endproperty
    a_chen_after_mute: assert property (p_chen_after_mute) else $error("enable before config and mute");
    property p_mute_other_ch;
        chen_on |-> (cmd_data[5:2] & mute_ch_r) == 4'h0;
    endproperty
    a_mute_other_ch: assert property (p_mute_other_ch) else $error("mute channel used for playback");
    property p_mute_min;
        cmd_valid && cmd_op == SCG_OP_MUTE |-> cmd_data[7:0] >= SCG_MUTE_LEN_MIN;
    endproperty
    a_mute_min: assert property (p_mute_min) else $error("silence length too short");
    property p_gated_hold;
        gated |=> $stable(left_en) && $stable(right_en);
    endproperty
    a_gated_hold: assert property (p_gated_hold) else $error("setup command moved enables");
    property p_spacing;
        cmd_valid |=> !cmd_valid [*5];
    endproperty
    a_spacing: assert property (p_spacing) else $error("command words too close");
    c_enable: cover property (chen_on);
    c_swap: cover property ($rose(right_en));
    c_gated_on: cover property (gated && (left_en || right_en));
endmodule

// File: verif/sai_command_gating_tb.sv
// self-checking bench: ahb-lite controller and gating device joined by the link
`timescale 1ns/1ps
module sai_command_gating_tb;
    import scg_pkg::*;
    logic hclk, link_clk, hresetn, hsel, hwrite, hreadyout, hresp, cmd_discard;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] channel_busy_low;
    logic [15:0] d_cfg, d_fmt1, d_fmt2, d_mode;
    logic [3:0] d_play, d_sch;
    logic [7:0] d_slen;
    logic d_left, d_right, mute_p;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic note = 1'b0, note_d = 1'b0, rd_d = 1'b0;
    logic [15:0] rnd = 16'h8c91;
    logic [15:0] kept[4];
    int n_fail = 0, compares = 0, n_disc = 0, n_mute = 0;
    scg_link_if lnk (.link_clk(link_clk));
    scg_host #(.UNIT_CYC(20)) u_scg_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(lnk.host));
    scg_device u_scg_device (.hresetn(hresetn), .link(lnk.dev), .channel_busy_low(channel_busy_low),
        .left_sai_enable(d_left), .right_sai_enable(d_right), .sai_play_ch(d_play), .sai_config_cmd(d_cfg),
        .sai_format_first_cmd(d_fmt1), .sai_format_second_cmd(d_fmt2), .sai_mode_select_cmd(d_mode),
        .silence_length_field(d_slen), .silence_ch(d_sch), .silence_insert_cmd(mute_p), .cmd_discard(cmd_discard));
    scg_link_sva u_scg_link_sva (.link_clk(link_clk), .hresetn(hresetn), .cmd_valid(lnk.cmd_valid),
        .cmd_op(lnk.cmd_op), .cmd_data(lnk.cmd_data), .left_en(lnk.left_en), .right_en(lnk.right_en),
        .busy_low(lnk.busy_low));
    // bus clock 50 ns; link clock 32 ns with an odd offset so edges drift apart
    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    initial
    begin
        link_clk = 1'b0;
        #7;
        forever #16 link_clk = ~link_clk;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [15:0] dev_reg(input int k);
        case (k)
            0: return d_cfg;
            1: return d_fmt1;
            2: return d_fmt2;
            default: return d_mode;
        endcase
    endfunction
    function automatic logic [31:0] st(input logic [2:0] err);
        return {21'h0, err, 8'h0};
    endfunction
    // one single word; entered just after a rising edge, answer taken at the data-phase edge
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, input logic nt,
        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        hsize <= 3'h2;
        note <= nt;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        rd = hrdata;
    endtask
    // note the expected word, then read it; the watcher does the compare
    task automatic expect_rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] rd;
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        ahb(1'b0, a, 32'h0, 1'b1, rd);
    endtask
    // write one command word, then poll until the controller has finished it
    task automatic cmd(input logic [2:0] op, input logic [15:0] d);
        logic [31:0] rd;
        ahb(1'b1, {28'h0, SCG_REG_CMD}, {13'h0, op, d}, 1'b0, rd);
        rd = 32'h1;
        for (int i = 0; i < 100 && rd[0] !== 1'b0; i++)
            ahb(1'b0, {28'h0, SCG_REG_STAT}, 32'h0, 1'b0, rd);
        chk("idle", {31'h0, rd[0]}, 32'h0);
    endtask
    // watcher: a noted read's data phase takes the oldest expectation
    always @(posedge hclk)
    begin
        if (rd_d && note_d && hreadyout === 1'b1)
        begin
            chk("read", hrdata & msk_q.pop_front(), exp_q.pop_front());
            chk("resp", {31'h0, hresp}, 32'h0);
        end
        if (hreadyout === 1'b1)
        begin
            rd_d <= hsel && htrans[1] && !hwrite;
            note_d <= note;
        end
    end
    // the device pulses discard per dropped command and silence insert per mute taken
    always @(posedge link_clk)
    begin
        if (cmd_discard === 1'b1)
            n_disc++;
        if (mute_p === 1'b1)
            n_mute++;
    end
    // main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        channel_busy_low = 4'hf;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (10) @(posedge hclk);
        expect_rd(32'h4, 32'h0000_00f0, 32'hffff_ffff);
        expect_rd(32'h8, 32'h0, 32'hffff_ffff);
        $display("test reset done");
        cmd(SCG_OP_CHEN, 16'h0009);
        expect_rd(32'h4, st(SCG_ERR_ORDER), 32'h706);
        for (int k = 0; k < 4; k++)
        begin
            rnd = lfsr(rnd);
            kept[k] = rnd;
            cmd(3'(k + 1), rnd);
            chk("setup", {16'h0, dev_reg(k)}, {16'h0, kept[k]});
        end
        expect_rd(32'h4, 32'h800, 32'h1f07);
        $display("test setup done");
        cmd(SCG_OP_MUTE, 16'h0103);
        expect_rd(32'h4, st(SCG_ERR_SHORT), 32'h1700);
        cmd(SCG_OP_MUTE, 16'h0104);
        chk("silence", {20'h0, d_sch, d_slen}, 32'h104);
        repeat (70) @(posedge hclk);
        cmd(SCG_OP_CHEN, 16'h0009);
        expect_rd(32'h4, st(SCG_ERR_LATE), 32'h706);
        cmd(SCG_OP_MUTE, 16'h0210);
        cmd(SCG_OP_CHEN, 16'h0009);
        expect_rd(32'h4, st(SCG_ERR_OVERLAP), 32'h706);
        cmd(SCG_OP_MUTE, 16'h0110);
        channel_busy_low <= 4'hb;
        repeat (10) @(posedge hclk);
        cmd(SCG_OP_CHEN, 16'h0009);
        expect_rd(32'h4, st(SCG_ERR_CHBUSY) | 32'hb0, 32'h7f6);
        channel_busy_low <= 4'hf;
        repeat (10) @(posedge hclk);
        $display("test refusals done");
        cmd(SCG_OP_CHEN, 16'h0009);
        expect_rd(32'h4, 32'h2, 32'h706);
        chk("play", {26'h0, d_play, d_right, d_left}, 32'h09);
        cmd(SCG_OP_CHEN, 16'h000a);
        expect_rd(32'h4, 32'h4, 32'h706);
        chk("play", {26'h0, d_play, d_right, d_left}, 32'h0a);
        $display("test enable done");
        for (int k = 0; k < 4; k++)
        begin
            cmd(3'(k + 1), ~kept[k]);
            chk("held", {16'h0, dev_reg(k)}, {16'h0, kept[k]});
        end
        chk("discards", n_disc, 32'd4);
        chk("mutes", n_mute, 32'd3);
        expect_rd(32'h4, 32'h4, 32'h6);
        cmd(SCG_OP_CHEN, 16'h0000);
        expect_rd(32'h4, 32'h0, 32'h706);
        $display("test gating done");
        stop_test();
    end
    // hang guard, well beyond the expected run
    initial
    begin
        #1ms;
        n_fail++;
        $display("[FAIL] watchdog expected done seen hang");
        stop_test();
    end
endmodule
